// [dpr_pkg.sv]
// package for the dual-port ram port controller
package dpr_pkg;
  localparam int DPR_AW = 13;
  localparam int DPR_DW = 16;
  localparam int DPR_TOKEN_AW = 3;
  // timing in ns, converted to cycles at the 50 ns clock
  localparam int DPR_CLK_NS = 50;
  localparam int DPR_SETUP_NS = 20;
  localparam int DPR_PULSE_NS = 35;
  localparam int DPR_HOLD_NS = 20;
  localparam int DPR_ACCESS_NS = 55;
  localparam int DPR_SWRD_NS = 15;
  localparam int DPR_SETUP_CYC = (DPR_SETUP_NS + DPR_CLK_NS - 1) / DPR_CLK_NS;
  localparam int DPR_PULSE_CYC = (DPR_PULSE_NS + DPR_CLK_NS - 1) / DPR_CLK_NS;
  localparam int DPR_HOLD_CYC = (DPR_HOLD_NS + DPR_CLK_NS - 1) / DPR_CLK_NS;
  localparam int DPR_ACCESS_CYC = (DPR_ACCESS_NS + DPR_CLK_NS - 1) / DPR_CLK_NS + 1;
  localparam int DPR_SWRD_CYC = (DPR_SWRD_NS + DPR_CLK_NS - 1) / DPR_CLK_NS;
  localparam int DPR_CNT_W = 4;
  localparam logic [DPR_CNT_W-1:0] DPR_CNT_ZERO = 4'h0;
  localparam logic [DPR_CNT_W-1:0] DPR_CNT_ONE = 4'h1;
  // token request writes bit zero low, release writes it high
  localparam int DPR_TOKEN_BIT = 0;
  localparam logic [DPR_DW-1:0] DPR_TOKEN_REQ = 16'hFFFE;
  localparam logic [DPR_DW-1:0] DPR_TOKEN_REL = 16'hFFFF;

  // request from the user side
  typedef struct packed {
    logic write;
    logic token;
    logic upper;
    logic lower;
    logic [DPR_AW-1:0] addr;
    logic [DPR_DW-1:0] wdata;
  } dpr_req_t;

  // strobes toward one port of the ram, all active low
  typedef struct packed {
    logic select_n;
    logic token_select_n;
    logic write_n;
    logic output_n;
    logic upper_lane_n;
    logic lower_lane_n;
  } dpr_strobe_t;

  localparam dpr_strobe_t DPR_STROBE_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
endpackage : dpr_pkg

// [dpr_count.sv]
// down counter that times the setup, pulse, hold and read-back setup phases of a port cycle
`timescale 1ns/1ps
module dpr_count
  import dpr_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // load and status
  input wire logic i_load,
  input wire logic [DPR_CNT_W-1:0] i_value,
  output logic o_done
);
  logic [DPR_CNT_W-1:0] count;
  logic [DPR_CNT_W-1:0] next_count;

  // load takes priority, otherwise count down to zero
  always_comb begin
    next_count = count;
    if (i_load) begin
      next_count = i_value;
    end else if (count != DPR_CNT_ZERO) begin
      next_count = count - DPR_CNT_ONE;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      count <= DPR_CNT_ZERO;
    end else begin
      count <= next_count;
    end
  end

  assign o_done = (count == DPR_CNT_ONE) || (count == DPR_CNT_ZERO);
endmodule : dpr_count

// [dpr_port_ctrl.sv]
// host controller that drives one port of the dual-port static ram
`timescale 1ns/1ps
module dpr_port_ctrl
  import dpr_pkg::*;
#(
  parameter int AW = DPR_AW,
  parameter int DW = DPR_DW
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // user request
  input wire logic i_req_valid,
  input wire dpr_req_t i_req,
  output logic o_req_ready,
  // user answer
  output logic o_done,
  output logic [DW-1:0] o_rdata,
  output logic o_token_owned,
  output logic o_busy_seen,
  // ram port strobes and address
  output dpr_strobe_t o_strobe,
  output logic [AW-1:0] o_addr,
  // ram data pins
  input wire logic [DW-1:0] i_data,
  output logic [DW-1:0] o_data,
  output logic o_data_oe_n,
  // busy pin and role
  input wire logic i_busy_n,
  input wire logic i_role_master
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_SETUP, ST_STROBE, ST_PULSE, ST_HOLD, ST_GAP, ST_RB_SETUP
  } dpr_state_t;

  dpr_state_t state;
  dpr_state_t next_state;
  dpr_req_t cur;
  dpr_req_t next_cur;
  dpr_strobe_t strobe;
  dpr_strobe_t next_strobe;
  logic [AW-1:0] addr;
  logic [AW-1:0] next_addr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] next_wdata;
  logic data_oe_n;
  logic next_data_oe_n;
  logic [DW-1:0] rdata;
  logic [DW-1:0] next_rdata;
  logic done;
  logic next_done;
  logic ready;
  logic next_ready;
  logic owned;
  logic next_owned;
  logic busy_seen;
  logic next_busy_seen;
  logic readback;
  logic next_readback;
  logic cnt_load;
  logic [DPR_CNT_W-1:0] cnt_value;
  logic cnt_done;

  // strobes that pick the array lanes or the token latch
  function automatic dpr_strobe_t select_strobes(input dpr_req_t r, input logic wr);
    dpr_strobe_t s;
    s = DPR_STROBE_IDLE;
    s.write_n = ~wr;
    s.output_n = wr;
    if (r.token) begin
      s.token_select_n = 1'b0;
      s.upper_lane_n = 1'b0;
      s.lower_lane_n = 1'b0;
    end else begin
      s.select_n = 1'b0;
      s.upper_lane_n = ~r.upper;
      s.lower_lane_n = ~r.lower;
    end
    return s;
  endfunction : select_strobes

  dpr_count u_count (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_load(cnt_load),
    .i_value(cnt_value),
    .o_done(cnt_done)
  );

  // slave-mode busy holds off the select of a write and stretches the write pulse
  logic hold_off;
  assign hold_off = !i_role_master && !i_busy_n;

  // cycle sequencer
  always_comb begin
    next_state = state;
    next_cur = cur;
    next_strobe = strobe;
    next_addr = addr;
    next_wdata = wdata;
    next_data_oe_n = data_oe_n;
    next_rdata = rdata;
    next_done = 1'b0;
    next_ready = ready;
    next_owned = owned;
    next_busy_seen = busy_seen;
    next_readback = readback;
    cnt_load = 1'b0;
    cnt_value = DPR_CNT_ZERO;
    unique case (state)
      ST_IDLE: begin
        if (i_req_valid && ready) begin
          next_cur = i_req;
          next_addr = i_req.addr; // address moves with all strobes high
          next_wdata = i_req.wdata;
          next_ready = 1'b0;
          next_busy_seen = 1'b0;
          next_readback = 1'b0;
          if (i_req.write) begin
            next_data_oe_n = 1'b0; // drive write data ahead of the strobes
          end
          cnt_load = 1'b1;
          cnt_value = DPR_CNT_W'(DPR_SETUP_CYC);
          next_state = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (cnt_done) begin
          if (cur.write) begin
            // write strobe falls a cycle after the address settles, before any select
            next_strobe.write_n = 1'b0;
          end
          next_state = ST_STROBE;
        end
      end
      ST_STROBE: begin
        if (!(cur.write && hold_off)) begin
          // select falls with or after the write strobe; reads keep write high
          next_strobe = select_strobes(cur, cur.write);
          cnt_load = 1'b1;
          cnt_value = cur.write ? DPR_CNT_W'(DPR_PULSE_CYC) : DPR_CNT_W'(DPR_ACCESS_CYC);
          next_state = ST_PULSE;
        end
      end
      ST_PULSE: begin
        if (!i_busy_n) begin
          next_busy_seen = 1'b1;
        end
        if (cur.write && hold_off) begin
          cnt_load = 1'b1; // stretch the pulse while busy is held
          cnt_value = DPR_CNT_W'(DPR_PULSE_CYC);
        end else if (cnt_done) begin
          if (!cur.write) begin
            next_rdata = i_data;
            if (cur.token && readback) begin
              next_owned = ~i_data[DPR_TOKEN_BIT];
            end
          end
          // all strobes rise together, ending the write overlap
          next_strobe = DPR_STROBE_IDLE;
          cnt_load = 1'b1;
          cnt_value = DPR_CNT_W'(DPR_HOLD_CYC);
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (cnt_done) begin
          next_data_oe_n = 1'b1;
          if (cur.write && cur.token && !cur.wdata[DPR_TOKEN_BIT]) begin
            // token request: read back to learn the grant
            next_cur.write = 1'b0;
            next_readback = 1'b1;
            cnt_load = 1'b1;
            cnt_value = DPR_CNT_W'(DPR_SWRD_CYC);
            next_state = ST_RB_SETUP;
          end else begin
            if (cur.write && cur.token) begin
              next_owned = 1'b0; // release written
            end
            next_done = 1'b1;
            next_state = ST_GAP;
          end
        end
      end
      ST_RB_SETUP: begin
        if (cnt_done) begin
          next_state = ST_STROBE;
        end
      end
      ST_GAP: begin
        next_ready = 1'b1;
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= ST_IDLE;
      cur <= '0;
      strobe <= DPR_STROBE_IDLE;
      addr <= '0;
      wdata <= '0;
      data_oe_n <= 1'b1;
      rdata <= '0;
      done <= 1'b0;
      ready <= 1'b1;
      owned <= 1'b0; // all tokens free at start
      busy_seen <= 1'b0;
      readback <= 1'b0;
    end else begin
      state <= next_state;
      cur <= next_cur;
      strobe <= next_strobe;
      addr <= next_addr;
      wdata <= next_wdata;
      data_oe_n <= next_data_oe_n;
      rdata <= next_rdata;
      done <= next_done;
      ready <= next_ready;
      owned <= next_owned;
      busy_seen <= next_busy_seen;
      readback <= next_readback;
    end
  end

  // outputs straight from flip-flops
  assign o_req_ready = ready;
  assign o_done = done;
  assign o_rdata = rdata;
  assign o_token_owned = owned;
  assign o_busy_seen = busy_seen;
  assign o_strobe = strobe;
  assign o_addr = addr;
  assign o_data = wdata;
  assign o_data_oe_n = data_oe_n;
endmodule : dpr_port_ctrl

// [dpr_monitor.sv]
// checker of the port strobes
`timescale 1ns/1ps
module dpr_monitor
  import dpr_pkg::*;
#(parameter int AW = DPR_AW) (
  // clock, reset, busy and role
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_busy_n,
  input wire logic i_role_master,
  // observed outputs
  input wire logic o_done,
  input wire dpr_strobe_t o_strobe,
  input wire logic [AW-1:0] o_addr,
  input wire logic o_data_oe_n
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // strobe combinations and order
  rd_we_high_a: assert property (!o_strobe.output_n |-> o_strobe.write_n)
    else $error("read with write low");
  array_sel_a: assert property (!o_strobe.select_n |-> o_strobe.token_select_n)
    else $error("both selects low");
  token_sel_a: assert property (!o_strobe.token_select_n |-> o_strobe.select_n)
    else $error("token with array select");
  addr_hold_a: assert property (!$stable(o_addr) |->
    o_strobe.write_n && $past(o_strobe.write_n)) else $error("address moved in write");
  write_drive_a: assert property (!o_strobe.write_n |-> !o_data_oe_n)
    else $error("write without data");
  sel_order_a: assert property ($fell(o_strobe.write_n) |->
    o_strobe.select_n && o_strobe.token_select_n) else $error("select before write");
  token_lane_a: assert property (!o_strobe.token_select_n |->
    !o_strobe.upper_lane_n && !o_strobe.lower_lane_n) else $error("token lanes");
  slave_hold_a: assert property (!i_role_master && !i_busy_n && !o_data_oe_n
    |=> !o_done) else $error("write done under busy");
endmodule : dpr_monitor

bind dpr_port_ctrl dpr_monitor #(.AW(AW)) u_mon (.i_clk(i_clk), .i_rst(i_rst),
  .i_busy_n(i_busy_n), .i_role_master(i_role_master), .o_done(o_done),
  .o_strobe(o_strobe), .o_addr(o_addr), .o_data_oe_n(o_data_oe_n));

// [dpr_ram_model.sv]
// model of one ram port with token latches
`timescale 1ns/1ps
module dpr_ram_model
  import dpr_pkg::*;
(
  // clock for the idle bus pattern
  input wire logic i_clk,
  // port pins
  input wire dpr_strobe_t i_strobe,
  input wire logic [DPR_AW-1:0] i_addr,
  input wire logic [DPR_DW-1:0] i_data,
  output logic [DPR_DW-1:0] o_data,
  output logic o_busy_n,
  // far side: role, clash, tokens held by the other port
  input wire logic i_role_master,
  input wire logic i_clash,
  input wire logic [7:0] i_other_held
);
  logic [DPR_DW-1:0] mem [16];
  logic [7:0] mine = 8'h00; // all free at start
  logic [DPR_DW-1:0] idle = 16'hA5A5;
  logic wr;
  // busy low while selected on a clashing address
  assign o_busy_n = !(i_clash && !i_strobe.select_n);
  assign wr = !i_strobe.write_n && (i_role_master || o_busy_n);
  // writes last while the strobes overlap
  always @(wr or i_strobe or i_addr or i_data or i_other_held) begin
    if (wr && !i_strobe.select_n && i_strobe.token_select_n) begin
      if (!i_strobe.upper_lane_n) mem[i_addr[3:0]][15:8] = i_data[15:8];
      if (!i_strobe.lower_lane_n) mem[i_addr[3:0]][7:0] = i_data[7:0];
    end
    if (wr && i_strobe.select_n && !i_strobe.token_select_n)
      mine[i_addr[2:0]] = !i_data[0] && !i_other_held[i_addr[2:0]];
  end
  always @(posedge i_clk) idle <= ~idle;
  // drive memory or token latch data only on reads, never under a write strobe; idle pattern otherwise
  always_comb begin
    o_data = idle;
    if (!i_strobe.output_n && i_strobe.write_n && !i_strobe.select_n)
      o_data = mem[i_addr[3:0]];
    if (!i_strobe.output_n && i_strobe.write_n && !i_strobe.token_select_n)
      o_data = {15'h7FFF, !mine[i_addr[2:0]]};
  end
endmodule : dpr_ram_model

// [test_dual_port_ram_access_arbitration.sv]
// testbench of the port controller against the ram model
`timescale 1ns/1ps
module test_dual_port_ram_access_arbitration
  import dpr_pkg::*;
();
  logic i_clk = 1'b0, i_rst = 1'b1, vld = 1'b0, role = 1'b1, clash = 1'b0;
  logic [7:0] held = 8'h00;
  dpr_req_t req = '0;
  logic ready, done, owned, bseen, oe_n, busy_n;
  dpr_strobe_t stb;
  logic [DPR_AW-1:0] addr;
  logic [DPR_DW-1:0] rdata, dut_d, ram_d, bus;
  int miscompares = 0, num_checks = 0, cyc = 0, n;
  always #25 i_clk = ~i_clk;
  assign bus = !oe_n ? dut_d : ram_d;
  dpr_port_ctrl u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_req_valid(vld), .i_req(req),
    .o_req_ready(ready), .o_done(done), .o_rdata(rdata), .o_token_owned(owned),
    .o_busy_seen(bseen), .o_strobe(stb), .o_addr(addr), .i_data(bus), .o_data(dut_d),
    .o_data_oe_n(oe_n), .i_busy_n(busy_n), .i_role_master(role));
  dpr_ram_model u_ram (.i_clk(i_clk), .i_strobe(stb), .i_addr(addr), .i_data(bus),
    .o_data(ram_d), .o_busy_n(busy_n), .i_role_master(role), .i_clash(clash),
    .i_other_held(held));
  // count a comparison
  task automatic check(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask : check
  // one request, then wait for done
  task automatic xfer(input logic w, t, u, l, input logic [12:0] a, input logic [15:0] d);
    @(posedge i_clk);
    vld <= 1'b1;
    req <= '{w, t, u, l, a, d};
    @(negedge i_clk);
    while (ready !== 1'b1) @(negedge i_clk);
    @(posedge i_clk);
    vld <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 100) begin
      @(negedge i_clk);
      n++;
    end
    check(done === 1'b1, "no done");
  endtask : xfer
  task automatic t_lanes();
    xfer(1, 0, 1, 1, 13'h0005, 16'h1234);
    xfer(1, 0, 1, 0, 13'h0005, 16'hAB99);
    xfer(1, 0, 0, 1, 13'h0005, 16'h77CD);
    xfer(0, 0, 1, 1, 13'h0005, 16'h0000);
    check(rdata === 16'hABCD, "lane write");
    $display("lanes test ended");
  endtask : t_lanes
  task automatic t_token();
    xfer(1, 1, 0, 0, 13'h0003, DPR_TOKEN_REQ);
    check(owned === 1'b1 && rdata[0] === 1'b0, "token not won");
    held <= 8'h04;
    xfer(1, 1, 0, 0, 13'h0002, DPR_TOKEN_REQ);
    check(owned === 1'b0 && rdata[0] === 1'b1, "token granted twice");
    xfer(1, 1, 0, 0, 13'h0003, DPR_TOKEN_REQ);
    check(owned === 1'b1 && rdata[0] === 1'b0, "own token lost");
    xfer(1, 1, 0, 0, 13'h0003, DPR_TOKEN_REL);
    check(owned === 1'b0, "token kept");
    xfer(0, 1, 0, 0, 13'h0003, 16'h0000);
    check(rdata[0] === 1'b1, "token not freed");
    $display("token test ended");
  endtask : t_token
  task automatic t_busy();
    clash <= 1'b1;
    xfer(0, 0, 1, 1, 13'h0005, 16'h0000);
    check(bseen === 1'b1, "busy not seen");
    @(posedge i_clk);
    role <= 1'b0;
    fork
      xfer(1, 0, 1, 1, 13'h0006, 16'h5A5A);
      begin
        repeat (12) @(posedge i_clk);
        clash <= 1'b0;
      end
    join
    check(n > 10, "slave write not held");
    xfer(0, 0, 1, 1, 13'h0006, 16'h0000);
    check(rdata === 16'h5A5A, "held write lost");
    $display("busy test ended");
  endtask : t_busy
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  // main sequence
  initial begin
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    t_lanes();
    t_token();
    t_busy();
    give_verdict();
  end
  // hang guard
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      give_verdict();
    end
  end
endmodule : test_dual_port_ram_access_arbitration
